// >>> common/hps_pkg.sv
package hps_pkg;

    // register word offsets on the wishbone side
    localparam logic [7:0] WB_CTRL_OFS = 8'h00;
    localparam logic [7:0] WB_STATUS_OFS = 8'h04;
    localparam logic [7:0] WB_GPIO_OFS = 8'h08;
    localparam logic [7:0] WB_INDEX_OFS = 8'h0c;

    // control register fields
    localparam int CTRL_WAIT_HI_BIT = 0;
    localparam int CTRL_WAIT_PP_BIT = 1;
    localparam int CTRL_WORD_HI_BIT = 2;
    localparam int CTRL_STB_HI_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // general io: bit 0 high keeps the phy powered down
    localparam logic [6:0] GPIO_RESET = 7'h01;
    localparam logic [6:0] GPIO_OUT_MASK = 7'h71;

    // host decode
    localparam logic [9:0] IO_BASE_ORIGIN = 10'h300;
    localparam int IO_BASE_SHIFT = 4;
    localparam logic [7:0] MEM_CMD_FIRST = 8'hf0;

    // bus width codes {wake strap, eeprom data strap}
    localparam logic [1:0] BW_16 = 2'h0;
    localparam logic [1:0] BW_32 = 2'h1;
    localparam logic [1:0] BW_8 = 2'h2;

    // ready time after power-on reset release
    localparam int CLK_MHZ = 50;
    localparam int READY_TIME_NS = 5000;
    localparam int READY_CYCLES = (READY_TIME_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic {
        HPS_IDLE,
        HPS_BUSY
    } hps_state_e;

endpackage

// >>> hw/hps_sync.sv
`timescale 1ns/1ps
`default_nettype none

module hps_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    // first stage feeds only the second stage
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                meta[i] <= RST_VAL[i];
                dout[i] <= RST_VAL[i];
            end else begin
                meta[i] <= din[i];
                dout[i] <= meta[i];
            end
        end
    end
endmodule // hps_sync

`default_nettype wire

// >>> hw/hps_top.sv
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - selected only with addr 9,8 high, addr 7 and aen low, 6..4 equal base strap.
// - io base is base strap times 10h plus 300h; base strap ignored in 32-bit mode.
// - port select high means data port, low means index port.
// - command issued while previous busy asserts wait; default low-active open drain.
// - word indication asserted for 16 or 32 bit memory access, low-active by default.
// - dword mode uses a pin for 32-bit indication; upper data lanes become active.
// - wake and eeprom data straps pick width: 00 16-bit, 01 32-bit, 10 8-bit.
// - management clock strap high makes interrupt low-active; dword strap in dword mode.
// - interrupt output type strap 1 gives open collector, 0 push-pull.
// - eeprom select strap high picks led mode 1, else mode 0.
// - duplex led low for full duplex in mode 1, for 10M in mode 0.
// - link led shows link without carrier in mode 1, carrier only in mode 0.
// - speed led low at 100M, floating at 10M.
// - link output strap high selects reverse mii, else normal mii.
// - transmit data 3 strap forces external mii, not in 32-bit mode.
// - transmit enable strap skips eeprom load after power-on reset.
// - phy power-up strap: 1 powered up, 0 powered down after power-on.
// - crossover strap 0 enables automatic crossover, 1 disables it.
// - general io 1..3 inputs, 0 and 4..6 outputs, io 0 defaults high.
// - low power-on reset initialises; ready 5us after release; no earlier access.
// - high hardware reset input resets the device.
// - clock source select 0 uses internal 50MHz, 1 uses 20MHz pin.
module hps_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic power_on_reset_n,
    input wire logic [5:0] host_addr_upper,
    input wire logic host_aen,
    input wire logic host_rd_strobe_n,
    input wire logic host_wr_strobe_n,
    input wire logic host_cmd,
    input wire logic [31:0] host_data_in,
    output logic [31:0] host_data_out,
    output logic host_data_lo_oe_n,
    output logic host_data_hi_oe_n,
    output logic cmd_wait_out,
    output logic cmd_wait_oe_n,
    output logic word_access_ind,
    output logic dword_access_ind,
    output logic dword_access_oe_n,
    input wire logic irq_req,
    output logic irq_out,
    output logic irq_oe_n,
    output logic [7:0] reg_idx,
    output logic reg_rd,
    output logic reg_wr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_done,
    input wire logic [2:0] base_strap,
    input wire logic mdc_strap,
    input wire logic dword_ind_strap,
    input wire logic eeprom_dout_strap,
    input wire logic wake_strap,
    input wire logic eeprom_select_strap,
    input wire logic link_out_strap,
    input wire logic txd3_strap,
    input wire logic txen_strap,
    input wire logic phy_powerup_strap,
    input wire logic irq_type_strap,
    input wire logic crossover_strap,
    input wire logic sysclk_source_sel,
    input wire logic phy_full_duplex,
    input wire logic phy_speed100,
    input wire logic phy_link,
    input wire logic phy_carrier,
    output logic led_drive_out,
    output logic speed_led_oe_n,
    output logic duplex_led_oe_n,
    output logic link_activity_led_oe_n,
    input wire logic [6:0] general_io_in,
    output logic [6:0] general_io_out,
    output logic [6:0] general_io_oe_n,
    output logic [9:0] io_base,
    output logic [1:0] bus_width,
    output logic reverse_mii,
    output logic ext_mii_force,
    output logic eeprom_load_skip,
    output logic phy_power_up,
    output logic auto_crossover_en,
    output logic clk_src_sel,
    output logic device_ready,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    typedef struct packed {
        hps_pkg::hps_state_e state;
        logic served;
        logic is_read;
        logic [7:0] idx;
        logic [31:0] rdata;
        logic reg_rd;
        logic reg_wr;
        logic [31:0] reg_wdata;
        logic strap_taken;
        logic [2:0] base;
        logic [1:0] bw;
        logic irq_lo;
        logic irq_od;
        logic led_mode1;
        logic rev_mii;
        logic ext_mii;
        logic ee_skip;
        logic phy_up;
        logic xover_en;
        logic [9:0] io_base;
        logic clk_src;
        logic [7:0] ready_cnt;
        logic ready;
        logic [3:0] ctrl;
        logic [6:0] gpio;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic cmd_wait;
        logic cmd_wait_oe_n;
        logic word_ind;
        logic dword_ind;
        logic dword_oe_n;
        logic [31:0] data_out;
        logic data_lo_oe_n;
        logic data_hi_oe_n;
        logic irq_out;
        logic irq_oe_n;
        logic spd_oe_n;
        logic dup_oe_n;
        logic lnk_oe_n;
    } hps_state_s;

    hps_state_s s;
    hps_state_s next_s;

    logic por_n_s;
    logic [9:0] host_s;
    logic [31:0] data_s;
    logic [13:0] strap_s;
    logic [6:0] gpio_s;

    hps_sync #(.W(1), .RST_VAL(1'b0)) u_por (
        .sys_clk(sys_clk), .rst(rst), .din(power_on_reset_n), .dout(por_n_s)
    );
    hps_sync #(.W(10), .RST_VAL(10'h00e)) u_host (
        .sys_clk(sys_clk), .rst(rst),
        .din({host_addr_upper, host_aen, host_rd_strobe_n, host_wr_strobe_n, host_cmd}),
        .dout(host_s)
    );
    hps_sync #(.W(32), .RST_VAL(32'h0)) u_data (
        .sys_clk(sys_clk), .rst(rst), .din(host_data_in), .dout(data_s)
    );
    hps_sync #(.W(14), .RST_VAL(14'h0)) u_strap (
        .sys_clk(sys_clk), .rst(rst),
        .din({base_strap, mdc_strap, dword_ind_strap, eeprom_dout_strap, wake_strap,
              eeprom_select_strap, link_out_strap, txd3_strap, txen_strap,
              phy_powerup_strap, irq_type_strap, crossover_strap}),
        .dout(strap_s)
    );
    hps_sync #(.W(7), .RST_VAL(7'h0)) u_gpio (
        .sys_clk(sys_clk), .rst(rst), .din(general_io_in), .dout(gpio_s)
    );

    logic rst_any;
    logic [5:0] a_s;
    logic aen_s, rd_n_s, wr_n_s, cmd_s;
    logic [2:0] st_base;
    logic st_mdc, st_dw, st_eeprom_dout_strap, st_wake, st_eeprom_select_strap, st_link, st_txd3, st_txen;
    logic st_phy, st_irqt, st_xo, clk_sel_s;
    logic rd_act, wr_act, host_sel, act_sel, wait_on, mem_acc, drv_rd;
    logic [1:0] bw_now;
    logic [31:0] wb_rd_mux;
    logic wb_req;

    // hardware reset high or power-on reset low both initialise the state register s; only hardware reset clears the synchronisers
    // reset merge
    assign rst_any = rst | ~por_n_s;
    assign {a_s, aen_s, rd_n_s, wr_n_s, cmd_s} = host_s;
    assign {st_base, st_mdc, st_dw, st_eeprom_dout_strap, st_wake, st_eeprom_select_strap, st_link, st_txd3,
            st_txen, st_phy, st_irqt, st_xo} = strap_s;
    // clock source select is not a latched strap; synced and followed live
    logic sysclk_source_sel_s;
    hps_sync #(.W(1), .RST_VAL(1'b0)) u_clksel (
        .sys_clk(sys_clk), .rst(rst), .din(sysclk_source_sel), .dout(sysclk_source_sel_s)
    );
    assign clk_sel_s = sysclk_source_sel_s;

    assign bw_now = {st_wake, st_eeprom_dout_strap};
    assign rd_act = s.ctrl[hps_pkg::CTRL_STB_HI_BIT] ? rd_n_s : ~rd_n_s;
    assign wr_act = s.ctrl[hps_pkg::CTRL_STB_HI_BIT] ? wr_n_s : ~wr_n_s;
    // address decode; accesses before ready are ignored
    assign host_sel = (a_s[5:4] == 2'h3) && !a_s[3] && !aen_s
        && (a_s[2:0] == s.base) && s.ready;
    assign act_sel = (rd_act | wr_act) & host_sel;
    // wait while not yet served or still busy
    assign wait_on = act_sel & (~s.served | (s.state == hps_pkg::HPS_BUSY));
    assign mem_acc = act_sel & cmd_s & (s.idx >= hps_pkg::MEM_CMD_FIRST);
    assign drv_rd = rd_act & host_sel & s.served & (s.state == hps_pkg::HPS_IDLE);
    assign wb_req = wb_cyc_i & wb_stb_i & ~s.wb_ack;

    always_comb begin
        case (wb_adr_i)
            hps_pkg::WB_CTRL_OFS: wb_rd_mux = {28'h0, s.ctrl};
            hps_pkg::WB_STATUS_OFS: wb_rd_mux = {16'h0, s.ready, s.clk_src, s.xover_en,
                s.phy_up, s.ee_skip, s.ext_mii, s.rev_mii, s.led_mode1, s.irq_od,
                s.irq_lo, s.bw, s.base, s.strap_taken};
            hps_pkg::WB_GPIO_OFS: wb_rd_mux = {25'h0,
                (s.gpio & hps_pkg::GPIO_OUT_MASK) | (gpio_s & ~hps_pkg::GPIO_OUT_MASK)};
            hps_pkg::WB_INDEX_OFS: wb_rd_mux = {24'h0, s.idx};
            default: wb_rd_mux = 32'h0;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.reg_rd = 1'b0;
        next_s.reg_wr = 1'b0;
        next_s.wb_ack = wb_req;
        next_s.wb_dat = wb_req ? wb_rd_mux : 32'h0;
        if (wb_req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == hps_pkg::WB_CTRL_OFS) begin
                next_s.ctrl = wb_dat_i[3:0];
            end
            if (wb_adr_i == hps_pkg::WB_GPIO_OFS) begin
                next_s.gpio = wb_dat_i[6:0];
            end
        end

        // latch straps once after reset release
        if (!s.strap_taken) begin
            next_s.strap_taken = 1'b1;
            next_s.bw = bw_now;
            // base strap unused in 32-bit mode
            next_s.base = (bw_now == hps_pkg::BW_32) ? 3'h0 : st_base;
            next_s.io_base = hps_pkg::IO_BASE_ORIGIN
                + (10'((bw_now == hps_pkg::BW_32) ? 3'h0 : st_base) << hps_pkg::IO_BASE_SHIFT);
            next_s.irq_lo = (bw_now == hps_pkg::BW_32) ? st_dw : st_mdc;
            next_s.irq_od = st_irqt;
            next_s.led_mode1 = st_eeprom_select_strap;
            next_s.rev_mii = st_link;
            next_s.ext_mii = st_txd3 & (bw_now != hps_pkg::BW_32);
            next_s.ee_skip = st_txen;
            next_s.phy_up = st_phy;
            next_s.xover_en = ~st_xo;
        end
        next_s.clk_src = clk_sel_s;

        if (!s.ready) begin
            next_s.ready_cnt = s.ready_cnt + 8'h1;
            next_s.ready = (s.ready_cnt == 8'(hps_pkg::READY_CYCLES - 1));
        end

        if (!(rd_act | wr_act)) begin
            next_s.served = 1'b0;
        end
        case (s.state)
            hps_pkg::HPS_IDLE: begin
                if (act_sel && !s.served) begin
                    next_s.served = 1'b1;
                    if (!cmd_s) begin
                        if (wr_act) begin
                            next_s.idx = data_s[7:0];
                        end
                        next_s.rdata = {24'h0, s.idx};
                    end else begin
                        next_s.is_read = rd_act;
                        next_s.reg_rd = rd_act;
                        next_s.reg_wr = ~rd_act;
                        next_s.reg_wdata = data_s;
                        next_s.state = hps_pkg::HPS_BUSY;
                    end
                end
            end
            hps_pkg::HPS_BUSY: begin
                if (reg_done) begin
                    next_s.state = hps_pkg::HPS_IDLE;
                    if (s.is_read) begin
                        next_s.rdata = reg_rdata;
                    end
                end
            end
            default: next_s.state = hps_pkg::HPS_IDLE;
        endcase

        next_s.cmd_wait = wait_on ~^ s.ctrl[hps_pkg::CTRL_WAIT_HI_BIT];
        next_s.cmd_wait_oe_n = s.ctrl[hps_pkg::CTRL_WAIT_PP_BIT] ? 1'b0 : next_s.cmd_wait;
        next_s.word_ind = (mem_acc && (s.bw == hps_pkg::BW_16 || s.bw == hps_pkg::BW_32))
            ~^ s.ctrl[hps_pkg::CTRL_WORD_HI_BIT];
        // dword indication only in dword mode
        next_s.dword_ind = (mem_acc && s.bw == hps_pkg::BW_32)
            ~^ s.ctrl[hps_pkg::CTRL_WORD_HI_BIT];
        next_s.dword_oe_n = (s.bw != hps_pkg::BW_32);
        // upper lanes driven only in dword mode; 8-bit mode masks byte lanes
        next_s.data_out = (s.bw == hps_pkg::BW_8) ? {24'h0, s.rdata[7:0]} : s.rdata;
        next_s.data_lo_oe_n = ~drv_rd;
        next_s.data_hi_oe_n = ~(drv_rd && s.bw == hps_pkg::BW_32);
        next_s.irq_out = irq_req ^ s.irq_lo;
        next_s.irq_oe_n = s.irq_od ? next_s.irq_out : 1'b0;
        next_s.spd_oe_n = ~phy_speed100;
        next_s.dup_oe_n = s.led_mode1 ? ~phy_full_duplex : phy_speed100;
        // link activity led; carrier blanks the link light in mode 1
        next_s.lnk_oe_n = s.led_mode1 ? ~(phy_link & ~phy_carrier) : ~phy_carrier;

        if (rst_any) begin
            next_s = '0;
            next_s.ctrl = hps_pkg::CTRL_RESET;
            next_s.gpio = hps_pkg::GPIO_RESET;
            next_s.cmd_wait = 1'b1;
            next_s.cmd_wait_oe_n = 1'b1;
            next_s.word_ind = 1'b1;
            next_s.dword_ind = 1'b1;
            next_s.dword_oe_n = 1'b1;
            next_s.data_lo_oe_n = 1'b1;
            next_s.data_hi_oe_n = 1'b1;
            next_s.irq_oe_n = 1'b1;
            next_s.spd_oe_n = 1'b1;
            next_s.dup_oe_n = 1'b1;
            next_s.lnk_oe_n = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        s <= next_s;
    end

    assign host_data_out = s.data_out;
    assign host_data_lo_oe_n = s.data_lo_oe_n;
    assign host_data_hi_oe_n = s.data_hi_oe_n;
    assign cmd_wait_out = s.cmd_wait;
    assign cmd_wait_oe_n = s.cmd_wait_oe_n;
    assign word_access_ind = s.word_ind;
    assign dword_access_ind = s.dword_ind;
    assign dword_access_oe_n = s.dword_oe_n;
    assign irq_out = s.irq_out;
    assign irq_oe_n = s.irq_oe_n;
    assign reg_idx = s.idx;
    assign reg_rd = s.reg_rd;
    assign reg_wr = s.reg_wr;
    assign reg_wdata = s.reg_wdata;
    assign led_drive_out = s.reg_rd & 1'b0;
    assign speed_led_oe_n = s.spd_oe_n;
    assign duplex_led_oe_n = s.dup_oe_n;
    assign link_activity_led_oe_n = s.lnk_oe_n;
    // fixed directions, io 0 high after reset
    assign general_io_out = s.gpio & hps_pkg::GPIO_OUT_MASK;
    assign general_io_oe_n = ~hps_pkg::GPIO_OUT_MASK;
    assign io_base = s.io_base;
    assign bus_width = s.bw;
    assign reverse_mii = s.rev_mii;
    assign ext_mii_force = s.ext_mii;
    assign eeprom_load_skip = s.ee_skip;
    assign phy_power_up = s.phy_up;
    assign auto_crossover_en = s.xover_en;
    assign clk_src_sel = s.clk_src;
    assign device_ready = s.ready;
    assign wb_dat_o = s.wb_dat;
    assign wb_ack_o = s.wb_ack;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst_any);

    sequence seq_accept;
        (s.state == hps_pkg::HPS_IDLE) && act_sel && !s.served;
    endsequence

    sequence seq_data_issue;
        (s.reg_rd || s.reg_wr) && (s.state == hps_pkg::HPS_BUSY);
    endsequence

    idx_load_a: assert property (
        seq_accept and (!cmd_s && wr_act) |=> s.idx == $past(data_s[7:0]))
        else $error("index write did not load offset");

    port_data_a: assert property (
        seq_accept and cmd_s |=> seq_data_issue)
        else $error("data port access did not reach register side");

    port_index_a: assert property (
        seq_accept and !cmd_s |=> !s.reg_rd && !s.reg_wr)
        else $error("index port access reached register side");

    base_calc_a: assert property (
        s.strap_taken |-> io_base == hps_pkg::IO_BASE_ORIGIN + {3'h0, s.base, 4'h0})
        else $error("io base does not follow base strap");

    strap_hold_a: assert property (
        s.strap_taken && $past(s.strap_taken) |-> $stable(bus_width) && $stable(io_base))
        else $error("strap configuration changed without reset");

    wait_level_a: assert property (
        wait_on |=> cmd_wait_out == s.ctrl[hps_pkg::CTRL_WAIT_HI_BIT])
        else $error("wait not asserted for pending command");

    irq_pol_a: assert property (
        s.strap_taken && $stable(s.irq_lo) |=> irq_out == ($past(irq_req) ^ s.irq_lo))
        else $error("interrupt polarity wrong");

    ready_delay_a: assert property (
        $rose(s.ready) |-> $past(s.ready_cnt) == 8'(hps_pkg::READY_CYCLES - 1))
        else $error("ready came at wrong time");

    gpio_dir_a: assert property (
        general_io_oe_n == 7'h0e)
        else $error("general io directions wrong");
endmodule // hps_top

`default_nettype wire

// >>> verif/hps_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module hps_host_model (
    input wire logic sys_clk,
    input wire logic wait_n,
    input wire logic [31:0] rdata,
    input wire logic [1:0] ind,
    output logic [5:0] addr,
    output logic aen,
    output logic rd_n,
    output logic wr_n,
    output logic cmd,
    output logic [31:0] wdata
);
    logic saw_wait = 1'b0;
    logic [1:0] ind_seen = 2'h0;
    initial begin
        addr = 6'h00;
        aen = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        cmd = 1'b0;
        wdata = 32'h0;
    end
    task automatic io(input logic w, input logic c, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
        int n;
        @(posedge sys_clk);
        addr <= a;
        aen <= 1'b0;
        cmd <= c;
        wdata <= w ? d : ~wdata;
        @(posedge sys_clk);
        rd_n <= w;
        wr_n <= ~w;
        saw_wait = 1'b0;
        n = 0;
        // strobe held past the sync delay, then until wait lets go
        do begin
            @(posedge sys_clk);
            n++;
            if (wait_n === 1'b0) saw_wait = 1'b1;
        end while ((n < 8 || wait_n !== 1'b1) && n < 60);
        repeat (2) @(posedge sys_clk);
        q = rdata;
        ind_seen = ind;
        ok = n < 60;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        aen <= 1'b1;
        addr <= ~a;
        wdata <= ~wdata;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule // hps_host_model

`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic sys_clk = 1'b0, rst = 1'b1, power_on_reset_n = 1'b1, irq_req = 1'b0, reg_done = 1'b0;
    logic [31:0] reg_rdata = 32'h0, wb_dat_i = 32'h0, wb_dat_o, host_data_in, host_data_out;
    logic [31:0] reg_wdata, q, m, d, wseen;
    logic [2:0] base_strap = 3'h0, pend = 3'h0;
    logic mdc_strap = 1'b0, dword_ind_strap = 1'b0, eeprom_dout_strap = 1'b0, wake_strap = 1'b0;
    logic eeprom_select_strap = 1'b0, link_out_strap = 1'b0, txd3_strap = 1'b0, txen_strap = 1'b0;
    logic phy_powerup_strap = 1'b0, irq_type_strap = 1'b0, crossover_strap = 1'b0;
    logic sysclk_source_sel = 1'b0, phy_full_duplex = 1'b0, phy_speed100 = 1'b0, phy_link = 1'b0;
    logic phy_carrier = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, ok;
    logic [7:0] wb_adr_i = 8'h00, reg_idx;
    logic [3:0] wb_sel_i = 4'h0;
    logic [6:0] general_io_in = 7'h0a, general_io_out, general_io_oe_n;
    logic [5:0] host_addr_upper;
    logic host_aen, host_rd_strobe_n, host_wr_strobe_n, host_cmd, host_data_lo_oe_n;
    logic host_data_hi_oe_n, cmd_wait_out, cmd_wait_oe_n, word_access_ind, dword_access_ind;
    logic dword_access_oe_n, irq_out, irq_oe_n, reg_rd, reg_wr, led_drive_out, speed_led_oe_n;
    logic duplex_led_oe_n, link_activity_led_oe_n, reverse_mii, ext_mii_force, eeprom_load_skip;
    logic phy_power_up, auto_crossover_en, clk_src_sel, device_ready;
    logic [9:0] io_base;
    logic [1:0] bus_width;
    int error_cnt = 0, comparisons = 0, wr_cnt = 0;

    hps_top hps_top_inst (.*);
    hps_host_model hps_host_model_inst (
        .sys_clk(sys_clk),
        .wait_n(cmd_wait_oe_n | cmd_wait_out),
        // released pins read as their pull-downs
        .rdata({host_data_hi_oe_n ? 16'h0 : host_data_out[31:16],
                host_data_lo_oe_n ? 16'h0 : host_data_out[15:0]}),
        .ind({dword_access_oe_n ? 1'b0 : dword_access_ind, word_access_ind}),
        .addr(host_addr_upper),
        .aen(host_aen),
        .rd_n(host_rd_strobe_n),
        .wr_n(host_wr_strobe_n),
        .cmd(host_cmd),
        .wdata(host_data_in)
    );

    always #10 sys_clk = ~sys_clk;

    // register file stand-in, slow enough that wait shows
    always @(posedge sys_clk) begin
        pend <= {pend[1:0], reg_rd | reg_wr};
        reg_done <= pend[2];
        if (reg_wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wseen <= reg_wdata;
        end
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v,
                      output logic [31:0] r);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= v;
        wb_sel_i <= 4'hf;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            test_done();
        end
    endtask

    task automatic host(input logic w, input logic c, input logic [5:0] a, input logic [31:0] v);
        hps_host_model_inst.io(w, c, a, v, q, ok);
        if (!ok) begin
            error_cnt++;
            test_done();
        end
    endtask

    task automatic sess(input logic por);
        int n;
        logic [13:0] v;
        logic [1:0] w;
        logic [5:0] a;
        logic [7:0] idx;
        logic lo, mw;
        v = 14'($urandom);
        if (v[10:9] == 2'h3) v[10] = 1'b0;
        {base_strap, wake_strap, eeprom_dout_strap, mdc_strap, dword_ind_strap, eeprom_select_strap,
         link_out_strap, txd3_strap, txen_strap, phy_powerup_strap, irq_type_strap,
         crossover_strap} <= v;
        if (por) power_on_reset_n <= 1'b0;
        else rst <= 1'b1;
        repeat (8) @(posedge sys_clk);
        power_on_reset_n <= 1'b1;
        rst <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (device_ready !== 1'b1 && n < 400);
        chk("ready time", 1, {n >= 251 && n <= 256});
        w = v[10:9];
        lo = (w == hps_pkg::BW_32) ? dword_ind_strap : mdc_strap;
        chk("width", w, bus_width);
        chk("base", (w == hps_pkg::BW_32) ? 10'h300 : 10'h300 + {base_strap, 4'h0},
            io_base);
        chk("rev mii", link_out_strap, reverse_mii);
        chk("ext mii", {txd3_strap && w != hps_pkg::BW_32}, ext_mii_force);
        chk("ee skip", txen_strap, eeprom_load_skip);
        chk("phy up", phy_powerup_strap, phy_power_up);
        chk("xover", {~crossover_strap}, auto_crossover_en);
        chk("gpio", 14'h0081, {general_io_out, general_io_oe_n ^ 7'h0f});
        repeat (4) begin
            {phy_full_duplex, phy_speed100, phy_link, phy_carrier, irq_req,
             sysclk_source_sel} <= 6'($urandom);
            repeat (4) @(posedge sys_clk);
            chk("speed led", {~phy_speed100}, speed_led_oe_n);
            chk("dup led", eeprom_select_strap ? {~phy_full_duplex} : phy_speed100,
                duplex_led_oe_n);
            chk("link led", eeprom_select_strap ? {~(phy_link & ~phy_carrier)} : {~phy_carrier},
                link_activity_led_oe_n);
            chk("clk src", sysclk_source_sel, clk_src_sel);
            chk("irq", {irq_type_strap & (irq_req ^ lo), irq_req ^ lo},
                {irq_oe_n, irq_out});
        end
        a = {3'b110, (w == hps_pkg::BW_32) ? 3'h0 : base_strap};
        m = (w == hps_pkg::BW_8) ? 32'hff : (w == hps_pkg::BW_16) ? 32'hffff : 32'hffffffff;
        idx = 8'($urandom);
        if (idx[0]) idx[7:4] = 4'hf;
        mw = idx >= hps_pkg::MEM_CMD_FIRST;
        d = $urandom;
        reg_rdata <= $urandom;
        host(1'b1, 1'b0, a, {24'h0, idx});
        chk("index", idx, reg_idx);
        n = wr_cnt;
        host(1'b1, 1'b1, a, d);
        chk("data wr", d & m, wseen & m);
        chk("wr count", n + 1, wr_cnt);
        chk("ind", {w == hps_pkg::BW_32 && !mw, !(mw && w != hps_pkg::BW_8)},
            hps_host_model_inst.ind_seen);
        chk("wait", 1, hps_host_model_inst.saw_wait);
        host(1'b0, 1'b1, a, 32'h0);
        chk("data rd", reg_rdata & m, q & m);
        host(1'b1, 1'b1, a ^ (6'h01 << ($urandom % 6)), d);
        chk("deselect", n + 1, wr_cnt);
        {base_strap, wake_strap, eeprom_dout_strap} <= ~v[13:9];
        repeat (6) @(posedge sys_clk);
        chk("strap hold", w, bus_width);
        $display("session done, width code %0d", w);
    endtask

    initial begin
        void'($urandom(91));
        sess(1'b0);
        wb(1'b0, hps_pkg::WB_CTRL_OFS, 32'h0, q);
        chk("ctrl reset", hps_pkg::CTRL_RESET, q[3:0]);
        wb(1'b1, hps_pkg::WB_CTRL_OFS, 32'h5, q);
        wb(1'b0, hps_pkg::WB_CTRL_OFS, 32'h0, q);
        chk("ctrl rw", 4'h5, q[3:0]);
        wb(1'b1, hps_pkg::WB_CTRL_OFS, 32'h0, q);
        wb(1'b1, hps_pkg::WB_GPIO_OFS, 32'h7f, q);
        chk("gpio out", 7'h71, general_io_out);
        wb(1'b0, hps_pkg::WB_GPIO_OFS, 32'h0, q);
        chk("gpio rd", 7'h7b, q[6:0]);
        wb(1'b1, hps_pkg::WB_GPIO_OFS, 32'h1, q);
        wb(1'b0, 8'h40, 32'h0, q);
        chk("unmapped", 32'h0, q);
        wb(1'b0, hps_pkg::WB_STATUS_OFS, 32'h0, q);
        chk("status", {1'b1, bus_width}, {q[15], q[5:4]});
        $display("register test done");
        for (int i = 0; i < 5; i++) sess(i[0]);
        test_done();
    end

    initial begin
        #1000000;
        error_cnt++;
        test_done();
    end
endmodule // tb

`default_nettype wire
